/* rtl/ldc_dim_fault_ctrl.sv */
`timescale 1ns/1ns
// What this block does
// - Level mode: peak current follows pin voltage linearly from 0.2 V to 2 V.
// - Floating level pin reads low; current dims to about ten percent.
// - A toggling clock on the pin selects clocked-duty dimming mode.
// - Clocked mode: peak level is 100% minus the clock's high duty.
// - No clock pulse for 50 us returns the block to level mode.
// - Enable low over 16 ms enters sleep and drops the bias rail.
// - Next enable rise after sleep clears faults; soft start on the next PWM rise.
// - Enable high, PWM low over 16 ms clears faults without sleep.
// - Bias rail and sync clock stay on whenever enable is high.
// - Fault pin is pulled low through open drain while a fault exists.
// - Group variant: fault line held low 8 switching cycles stops boost and sinks.
// - Sinks run only while enable and PWM are both high.
// - Short-string fault latches until enable or PWM low over 16 ms.
module ldc_dim_fault_ctrl
  import ldc_pkg::*;
#(
  parameter int unsigned LOW_CYC      = LOW_RESET_CYC,   // 16 ms in cycles
  parameter int unsigned TIMEOUT_CYC  = DIM_TIMEOUT_CYC, // 50 us in cycles
  parameter bit          GROUP_VARIANT = 1'b0            // Bidirectional fault pin
)(
  input  wire logic        sys_clk,       // 20 MHz oscillator
  input  wire logic        rst,           // Sync reset, active high
  input  wire logic        enable,        // Chip-enable input
  input  wire logic        pwm,           // PWM dimming input
  input  wire logic        levelDimPin,   // Level dimming pin, digital view
  input  wire logic [7:0]  levelDimAdc,   // Level dimming pin voltage, 0..255 = 0..2 V+
  input  wire logic        swTick,        // One pulse per switching cycle
  input  wire logic        shortFault,    // Shorted-string detect pulse
  input  wire logic        openFault,     // Other latched fault detect pulse
  input  wire logic        faultIn,       // Fault line level as read back
  output logic             faultOut,      // Fault pin drive value, always 0
  output logic             faultOe_n,     // Fault pin enable, low pulls low
  output logic             biasOn,        // Internal bias rail enable
  output logic             syncClkEn,     // Sync clock output enable
  output logic             sinkEn,        // LED current sinks enable
  output logic             boostEn,       // Boost switch enable
  output logic             softStart,     // Soft start request pulse
  output logic             clockedDutyDimMode, // High in clocked-duty mode
  output logic [7:0]       peakLevel      // Peak current level, FF = 100%
);
  typedef struct packed {
    logic [31:0] enLowCnt;
    logic [31:0] pwmLowCnt;
    logic [31:0] idleCnt;
    logic [3:0]  grpCnt;
    logic        asleep;
    logic        enPrev;
    logic        pwmPrev;
    logic        needStart;
    logic        faultLatch;
    logic        groupOff;
    ldc_mode_e   mode;
    logic        faultOe_n;
    logic        biasOn;
    logic        syncClkEn;
    logic        sinkEn;
    logic        boostEn;
    logic        softStart;
    logic [7:0]  peakLevel;
  } ldc_ctrl_s;
  ldc_ctrl_s state_reg, state_next;

  ldc_dim_if dimBus ();
  assign dimBus.pinLevel = levelDimPin;

  ldc_duty_meter u_meter (
    .sys_clk (sys_clk),
    .rst     (rst),
    .dim     (dimBus.meter)
  );

  function automatic logic [31:0] count_up(input logic [31:0] v, input logic run);
    return run ? ((&v) ? v : v + 32'h1) : 32'h0;
  endfunction : count_up

  always_comb begin
    logic enRise;
    logic pwmRise;
    logic clearFaults;
    enRise = enable && !state_reg.enPrev;
    pwmRise = pwm && !state_reg.pwmPrev;
    clearFaults = 1'b0;
    state_next = state_reg;
    state_next.enPrev = enable;
    state_next.pwmPrev = pwm;
    state_next.softStart = 1'b0;

    // Low-interval timers hold zero while their input is high; PWM timer also while enable is low
    state_next.enLowCnt = count_up(state_reg.enLowCnt, !enable);
    state_next.pwmLowCnt = count_up(state_reg.pwmLowCnt, enable && !pwm);
    if (!enable && state_reg.enLowCnt >= 32'(LOW_CYC)) begin
      state_next.asleep = 1'b1;
    end
    if (enRise && state_reg.asleep) begin
      state_next.asleep = 1'b0;
      state_next.needStart = 1'b1;
      clearFaults = 1'b1;
    end
    if (enable && !pwm && state_reg.pwmLowCnt >= 32'(LOW_CYC)) begin
      state_next.needStart = 1'b1;
      clearFaults = 1'b1;
    end
    if (pwmRise && enable && state_reg.needStart) begin
      state_next.softStart = 1'b1;
      state_next.needStart = 1'b0;
    end

    // A new detection in the clear cycle still latches
    if (clearFaults) begin
      state_next.faultLatch = 1'b0;
      state_next.groupOff = 1'b0;
    end
    if (shortFault || openFault) begin
      state_next.faultLatch = 1'b1;
    end

    // Group shutdown: count switching cycles the line is held low by others
    if (!GROUP_VARIANT || faultIn || !state_reg.faultOe_n) begin
      state_next.grpCnt = '0;
    end else if (swTick && state_reg.grpCnt != 4'(GROUP_FAULT_SW)) begin
      state_next.grpCnt = state_reg.grpCnt + 4'h1;
    end
    if (GROUP_VARIANT && state_reg.grpCnt == 4'(GROUP_FAULT_SW)) begin
      state_next.groupOff = 1'b1;
    end

    // Dimming mode select, timeout counter restarts on each clock pulse
    state_next.idleCnt = dimBus.clockSeen ? 32'h0 : count_up(state_reg.idleCnt, 1'b1);
    if (dimBus.clockSeen) begin
      state_next.mode = LDC_CLOCKED;
    end else if (state_reg.mode == LDC_CLOCKED && state_reg.idleCnt >= 32'(TIMEOUT_CYC)) begin
      state_next.mode = LDC_LEVEL;
    end
    // Level pin: pull-down gives about ten percent via the low-end clamp
    if (state_reg.mode == LDC_CLOCKED) begin
      state_next.peakLevel = dimBus.dutyLevel;
    end else if (levelDimAdc < LEVEL_FLOAT) begin
      state_next.peakLevel = LEVEL_FLOAT;
    end else begin
      state_next.peakLevel = levelDimAdc;
    end

    state_next.faultOe_n = !(state_reg.faultLatch);
    state_next.biasOn = enable || !state_reg.asleep;
    state_next.syncClkEn = enable;
    state_next.sinkEn = enable && pwm && !state_reg.groupOff;
    state_next.boostEn = enable && pwm && !state_reg.groupOff;

    if (rst) begin
      state_next = '0;
      state_next.faultOe_n = 1'b1;
      state_next.peakLevel = LEVEL_FLOAT;
      state_next.mode = LDC_LEVEL;
    end
  end

  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
  end

  assign faultOut = 1'b0;
  assign faultOe_n = state_reg.faultOe_n;
  assign biasOn = state_reg.biasOn;
  assign syncClkEn = state_reg.syncClkEn;
  assign sinkEn = state_reg.sinkEn;
  assign boostEn = state_reg.boostEn;
  assign softStart = state_reg.softStart;
  assign clockedDutyDimMode = (state_reg.mode == LDC_CLOCKED);
  assign peakLevel = state_reg.peakLevel;
endmodule : ldc_dim_fault_ctrl

/* rtl/ldc_pkg.sv */
package ldc_pkg;
  // Oscillator and timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned DIM_TIMEOUT_US  = 50;
  localparam int unsigned DIM_TIMEOUT_CYC = DIM_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LOW_RESET_MS    = 16;
  localparam int unsigned LOW_RESET_CYC   = LOW_RESET_MS * (CLK_HZ / 1000);
  localparam int unsigned MIN_PULSE_NS    = 150;
  localparam int unsigned MIN_PULSE_CYC   = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GROUP_FAULT_SW  = 8;
  // Level range of the dimming input, in millivolts
  localparam int unsigned LEVEL_LOW_MV    = 200;
  localparam int unsigned LEVEL_HIGH_MV   = 2000;
  localparam int unsigned LEVEL_W         = 8;
  localparam logic [7:0]  LEVEL_FULL      = 8'hFF;
  localparam logic [7:0]  LEVEL_FLOAT     = 8'h1A;
  localparam int unsigned DUTY_W          = 16;
  typedef enum logic [0:0] {LDC_LEVEL, LDC_CLOCKED} ldc_mode_e;
endpackage : ldc_pkg

/* rtl/ldc_dim_if.sv */
`timescale 1ns/1ns
interface ldc_dim_if;
  logic       pinLevel;
  logic       clockSeen;
  logic [7:0] dutyLevel;
  modport meter (input pinLevel, output clockSeen, output dutyLevel);
  modport ctrl  (output pinLevel, input clockSeen, input dutyLevel);
endinterface : ldc_dim_if

/* rtl/ldc_duty_meter.sv */
`timescale 1ns/1ns
module ldc_duty_meter
  import ldc_pkg::*;
(
  input  wire logic  sys_clk, // Oscillator
  input  wire logic  rst,     // Sync reset
  ldc_dim_if.meter   dim      // Pin sample and result
);
  typedef struct packed {
    logic              pinPrev;
    logic [DUTY_W-1:0] highCnt;
    logic [DUTY_W-1:0] periodCnt;
    logic              clockSeen;
    logic [7:0]        dutyLevel;
  } ldc_meter_s;
  ldc_meter_s state_reg, state_next;

  function automatic logic [DUTY_W-1:0] sat_inc(input logic [DUTY_W-1:0] v);
    return (&v) ? v : v + 1'b1;
  endfunction : sat_inc

  always_comb begin
    logic [DUTY_W+7:0] scaled;
    scaled = '0;
    state_next = state_reg;
    state_next.pinPrev = dim.pinLevel;
    state_next.clockSeen = 1'b0;
    state_next.periodCnt = sat_inc(state_reg.periodCnt);
    if (dim.pinLevel) begin
      state_next.highCnt = sat_inc(state_reg.highCnt);
    end
    // Rising edge closes one period; level = 100% minus high duty
    if (dim.pinLevel && !state_reg.pinPrev) begin
      state_next.clockSeen = 1'b1;
      // Period count is zero only right after reset; skip the divide then
      if (state_reg.periodCnt != '0) begin
        scaled = ({8'h00, state_reg.highCnt} * 24'(8'hFF)) / {8'h00, state_reg.periodCnt};
      end
      state_next.dutyLevel = 8'hFF - scaled[7:0];
      // The rise cycle is the first high cycle of the new period
      state_next.highCnt = DUTY_W'(1);
      state_next.periodCnt = DUTY_W'(1);
    end
    if (rst) begin
      state_next = '0;
      state_next.dutyLevel = LEVEL_FULL;
    end
  end

  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
  end

  assign dim.clockSeen = state_reg.clockSeen;
  assign dim.dutyLevel = state_reg.dutyLevel;
endmodule : ldc_duty_meter

/* tb/ldc_host_model.sv */
`timescale 1ns/1ns
module ldc_host_model #(parameter int unsigned HI = 5, parameter int unsigned LO = 15) (
  input  wire logic sys_clk, // Clock
  input  wire logic run,     // Send dimming clock
  output logic      dimPin   // Dim pin level
);
  int unsigned ph = 0;
  initial dimPin = 1'b0;
  // Idle pin sits at the pull-down level, never at its last driven value
  always @(posedge sys_clk) begin
    ph     <= (!run || ph + 1 == HI + LO) ? 0 : ph + 1;
    dimPin <= run && ph < HI; // 1 MHz at 25 % duty
  end
endmodule : ldc_host_model

/* tb/ldc_dim_fault_ctrl_checker.sv */
`timescale 1ns/1ns
module ldc_dim_fault_ctrl_checker
#(parameter int unsigned LOW_CYC = 50) (
  input wire logic sys_clk,           // Clock
  input wire logic rst,               // Reset
  input wire logic enable,            // Enable
  input wire logic pwm,               // PWM
  input wire logic levelDimPin,       // Dim pin
  input wire logic shortFault,        // Fault pulse
  input wire logic openFault,         // Other fault pulse
  input wire logic faultOe_n,         // Fault drive
  input wire logic biasOn,            // Bias rail
  input wire logic syncClkEn,         // Sync clock
  input wire logic sinkEn,            // Sinks
  input wire logic softStart,         // Start pulse
  input wire logic clockedDutyDimMode // Mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  int unsigned lowCnt;
  always_ff @(posedge sys_clk) // Saturates so a long sleep never wraps
    lowCnt <= (rst || enable) ? 0 : (lowCnt < LOW_CYC + 9) ? lowCnt + 1 : lowCnt;
  sequence s_rise; $rose(levelDimPin) && !clockedDutyDimMode; endsequence
  // A fault raised in the wake cycle wins over the clear
  sequence s_wake; $rose(enable) && lowCnt > LOW_CYC + 2 && !shortFault && !openFault; endsequence
  a_fault_low: assert property (shortFault |-> ##2 !faultOe_n) else $error("no pull");
  a_sink_gate: assert property (!(enable && pwm) |=> !sinkEn) else $error("sinks");
  a_rail_on: assert property (enable |=> biasOn && syncClkEn) else $error("rail");
  a_mode_in: assert property (s_rise |-> ##2 clockedDutyDimMode) else $error("mode");
  a_sleep_in: assert property (lowCnt == LOW_CYC + 3 |-> !biasOn) else $error("awake");
  a_sleep_hold: assert property (!enable && !biasOn && !$past(rst) |=> !biasOn) else $error("woke");
  a_wake_clear: assert property (s_wake |-> ##[1:2] faultOe_n) else $error("fault");
  a_start_once: assert property (softStart |=> !softStart) else $error("start");
endmodule : ldc_dim_fault_ctrl_checker
bind ldc_dim_fault_ctrl ldc_dim_fault_ctrl_checker #(.LOW_CYC(LOW_CYC)) watch (.*);

/* tb/ldc_dim_fault_ctrl_test.sv */
`timescale 1ns/1ns
module ldc_dim_fault_ctrl_test;
  localparam int unsigned LOWC = 50, TOC = 20;
  logic       sys_clk, rst, enable, pwm, dimPin, dimRun, swTick, shortFault, openFault, extLow;
  logic       faultOut, faultOe_n, biasOn, syncClkEn, sinkEn, boostEn, softStart, mode, seen;
  logic [7:0] adc, peak;
  int         errTotal = 0, nTests = 0, cycles = 0;
  ldc_dim_fault_ctrl #(.LOW_CYC(LOWC), .TIMEOUT_CYC(TOC), .GROUP_VARIANT(1'b1)) DUT (
    .sys_clk, .rst, .enable, .pwm, .levelDimPin(dimPin), .levelDimAdc(adc), .swTick,
    .shortFault, .openFault, .faultIn(faultOe_n & ~extLow), .faultOut, .faultOe_n, .biasOn,
    .syncClkEn, .sinkEn, .boostEn, .softStart, .clockedDutyDimMode(mode), .peakLevel(peak));
  ldc_host_model HOST (.sys_clk, .run(dimRun), .dimPin);
  initial begin sys_clk = 1'b0; forever #25 sys_clk = ~sys_clk; end
  always @(posedge sys_clk) begin
    seen <= seen | (softStart === 1'b1);
    if (++cycles == 3000) begin errTotal++; report_and_stop(); end
  end
  task automatic cyc(input int n); repeat (n) @(posedge sys_clk); #5; endtask : cyc
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    nTests++;
    if (got !== exp) begin $display("[ERR] %s exp %h got %h", nm, exp, got); errTotal++; end
  endtask : chk
  task automatic report_and_stop();
    if (errTotal == 0 && nTests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic t_dim();
    adc = 8'h00; cyc(3);
    chk("float", 8'h1A, peak);
    adc = 8'h80; dimRun = 1'b1; cyc(5);
    chk("mode", 8'h01, 8'(mode));
    cyc(40); chk("duty", 8'hC0, peak);
    dimRun = 1'b0; cyc(TOC + 6);
    chk("mode back", 8'h00, 8'(mode));
    chk("level", 8'h80, peak);
  endtask : t_dim
  task automatic t_pwm_clear();
    pwm = 1'b1; cyc(2);
    chk("sinks on", 8'h01, 8'(sinkEn));
    shortFault = 1'b1; cyc(1);
    shortFault = 1'b0; pwm = 1'b0; cyc(2);
    chk("pulled", 8'h00, 8'(faultOe_n));
    chk("sinks off", 8'h00, 8'(sinkEn));
    cyc(LOWC - 10); chk("held", 8'h00, 8'(faultOe_n));
    cyc(16); chk("cleared", 8'h01, 8'(faultOe_n));
    chk("rail", 8'h03, {6'h00, syncClkEn, biasOn});
    seen = 1'b0; pwm = 1'b1; cyc(3);
    chk("restart", 8'h01, 8'(seen));
  endtask : t_pwm_clear
  task automatic t_sleep();
    pwm = 1'b0; openFault = 1'b1; cyc(1);
    openFault = 1'b0; enable = 1'b0; cyc(LOWC + 6);
    chk("asleep", 8'h00, 8'(biasOn));
    enable = 1'b1; cyc(3);
    chk("wake", 8'h01, 8'(faultOe_n));
    seen = 1'b0; pwm = 1'b1; cyc(3);
    chk("wake start", 8'h01, 8'(seen));
  endtask : t_sleep
  task automatic t_group();
    extLow = 1'b1;
    repeat (9) begin swTick = 1'b1; cyc(1); swTick = 1'b0; cyc(1); end
    chk("group", 8'h00, {6'h00, boostEn, sinkEn});
    chk("drive", 8'h00, 8'(faultOut));
    extLow = 1'b0;
  endtask : t_group
  initial begin
    {rst, enable, pwm, dimRun, swTick, shortFault, openFault, extLow, seen} = 9'h100;
    adc = 8'hFF; cyc(3);
    rst = 1'b0; enable = 1'b1; cyc(2);
    chk("full", 8'hFF, peak);
    t_dim();
    t_pwm_clear();
    t_sleep();
    t_group();
    report_and_stop();
  end
endmodule : ldc_dim_fault_ctrl_test
